// [rtl/pam_ahb_slave.sv]
// ahb-lite slave front end for the port a registers
`timescale 1ns/100ps
module pam_ahb_slave
  import pam_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  pam_reg_if.bus regs
);
  pam_bus_t state, next_state;
  logic [7:0] addr, next_addr;
  logic [31:0] next_rdata;
  logic take;
  // ==========================================
  // address phase capture and read wait state
  always_comb begin
    take = hsel && htrans == HTRANS_NONSEQ && hready;
    next_state = pam_idle;
    next_addr = addr;
    next_rdata = hrdata;
    unique case (state)
      pam_idle, pam_wr: begin
        if (take) begin
          next_state = hwrite ? pam_wr : pam_rd_wait;
          next_addr = (haddr[31:8] == 24'h000000 && hsize == HSIZE_WORD) ? haddr[7:0] : OFF_NONE;
        end
      end
      pam_rd_wait: begin
        next_rdata = regs.rdata;
      end
      default: next_state = pam_idle;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= pam_idle;
      addr <= OFF_NONE;
      hrdata <= 32'h00000000;
    end else begin
      state <= next_state;
      addr <= next_addr;
      hrdata <= next_rdata;
    end
  end
  assign hreadyout = state != pam_rd_wait;
  assign regs.wr = state == pam_wr;
  assign regs.addr = addr;
  assign regs.wdata = hwdata;
endmodule

// [rtl/pam_pkg.sv]
// constants and types for the port a pin function multiplexer
package pam_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_ANSEL = 8'h00;
  localparam logic [7:0] OFF_LAT = 8'h04;
  localparam logic [7:0] OFF_PORT = 8'h08;
  localparam logic [7:0] OFF_SLEW = 8'h0c;
  localparam logic [7:0] OFF_DIR = 8'h10;
  localparam logic [7:0] OFF_OSC = 8'h14;
  localparam logic [7:0] OFF_NONE = 8'hff;
  // ==========================================
  // implemented bits and reset values
  localparam logic [7:0] ANSEL_MASK = 8'h2f;
  localparam logic [7:0] SLEW_MASK = 8'h1f;
  localparam logic [7:0] ANSEL_RST = 8'h2f;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] SLEW_RST = 8'h1f;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [2:0] OSC_RST = 3'h0;
  localparam int OSC_CLK_OUT_BIT = 2;
  // ==========================================
  // pin positions
  localparam int PIN_SR_Q = 4;
  localparam int PIN_SR_QBAR = 5;
  localparam int PIN_XOUT = 6;
  localparam int PIN_XIN = 7;
  // ==========================================
  // bus and timing
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int CLK_DIV = 4;
  localparam int DIV_W = $clog2(CLK_DIV);
  // ==========================================
  // types
  typedef enum logic [1:0] {
    pam_osc_int = 2'b00,
    pam_osc_rc = 2'b01,
    pam_osc_xtal = 2'b10,
    pam_osc_ext = 2'b11
  } pam_osc_t;
  typedef enum logic [1:0] {
    pam_idle = 2'b00,
    pam_wr = 2'b01,
    pam_rd_wait = 2'b10
  } pam_bus_t;
endpackage

// [rtl/pam_port_a.sv]
// port a output priority multiplexer, digital input gating and registers
// Behaviour
// - pin 6 latch output only internal, no clockout
// - pin 6 input only internal, no clockout
// - rc mode: pin 6 outputs quarter-rate clock
// - external oscillator modes disable pin 7 io
// - highest enabled source drives the pin
// - fixed per-pin source priority order
// - analog inputs ignore output arbitration
// - outputs still drive pins in analog mode
// - unimplemented register bits read as zero
// - direction one turns the output driver off, except on pin 6 while it outputs the clock
// - analog select disables digital input
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module pam_port_a
  import pam_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  output logic [1:0] osc_owns_pin,
  output logic [7:0] digital_in,
  output logic [4:0] slew_limit,
  output logic instr_rate_clock,
  input wire logic sr_latch_q,
  input wire logic sr_q_en,
  input wire logic sr_latch_qbar,
  input wire logic sr_qbar_en,
  input wire logic comparator1_out,
  input wire logic cmp1_oe,
  input wire logic comparator2_out,
  input wire logic cmp2_oe,
  input wire logic capture_compare5_out,
  input wire logic capture_compare5_oe
);
  pam_reg_if regs();
  logic [7:0] analog_select_a, output_latch_a, slew_rate_ctrl, direction_ctrl_a;
  logic [7:0] next_ansel, next_lat, next_slew, next_dir;
  logic [2:0] osc_cfg, next_osc;
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic [7:0] pin_sync, next_pin_out, next_oe_n, next_din;
  logic [1:0] next_owns;
  pam_osc_t osc_mode;
  logic clock_out_on, latch6_ok, clock6_on;
  logic [31:0] rdata_mux;

  // ==========================================
  // bus slave and pin synchroniser
  pam_ahb_slave u_bus (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .regs(regs.bus)
  );
  pam_sync #(.WIDTH(8)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );
  assign hresp = 1'b0;

  // ==========================================
  // oscillator mode decode
  assign osc_mode = pam_osc_t'(osc_cfg[1:0]);
  assign clock_out_on = osc_cfg[OSC_CLK_OUT_BIT];
  assign latch6_ok = osc_mode == pam_osc_int && !clock_out_on;
  assign clock6_on = osc_mode == pam_osc_rc || (clock_out_on && osc_mode != pam_osc_xtal);

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    unique case (a)
      OFF_ANSEL: r[7:0] = analog_select_a & ANSEL_MASK;
      OFF_LAT: r[7:0] = output_latch_a;
      OFF_PORT: r[7:0] = digital_in;
      OFF_SLEW: r[7:0] = slew_rate_ctrl & SLEW_MASK;
      OFF_DIR: r[7:0] = direction_ctrl_a;
      OFF_OSC: r[2:0] = osc_cfg;
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // ==========================================
  // register file
  always_comb begin
    next_ansel = analog_select_a;
    next_lat = output_latch_a;
    next_slew = slew_rate_ctrl;
    next_dir = direction_ctrl_a;
    next_osc = osc_cfg;
    if (regs.wr) begin
      unique case (regs.addr)
        OFF_ANSEL: next_ansel = regs.wdata[7:0] & ANSEL_MASK;
        OFF_LAT, OFF_PORT: next_lat = regs.wdata[7:0];
        OFF_SLEW: next_slew = regs.wdata[7:0] & SLEW_MASK;
        OFF_DIR: next_dir = regs.wdata[7:0];
        OFF_OSC: next_osc = regs.wdata[2:0];
        default: next_osc = osc_cfg;
      endcase
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_select_a <= ANSEL_RST;
      output_latch_a <= LAT_RST;
      slew_rate_ctrl <= SLEW_RST;
      direction_ctrl_a <= DIR_RST;
      osc_cfg <= OSC_RST;
    end else begin
      analog_select_a <= next_ansel;
      output_latch_a <= next_lat;
      slew_rate_ctrl <= next_slew;
      direction_ctrl_a <= next_dir;
      osc_cfg <= next_osc;
    end
  end
  // process form so a register change refreshes the read mux
  always_comb begin
    rdata_mux = read_reg(regs.addr);
  end
  assign regs.rdata = rdata_mux;
  assign slew_limit = slew_rate_ctrl[4:0];

  // ==========================================
  // instruction rate clock divider
  always_comb begin
    next_div_cnt = div_cnt + DIV_W'(1);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ==========================================
  // output priority and input gating
  always_comb begin
    // analog select takes no part in the output choice
    next_pin_out = output_latch_a;
    next_oe_n = direction_ctrl_a;
    next_owns = 2'b00;
    if (sr_q_en) begin
      next_pin_out[PIN_SR_Q] = sr_latch_q;
    end else if (cmp1_oe) begin
      next_pin_out[PIN_SR_Q] = comparator1_out;
    end else if (capture_compare5_oe) begin
      next_pin_out[PIN_SR_Q] = capture_compare5_out;
    end
    if (sr_qbar_en) begin
      next_pin_out[PIN_SR_QBAR] = sr_latch_qbar;
    end else if (cmp2_oe) begin
      next_pin_out[PIN_SR_QBAR] = comparator2_out;
    end
    if (osc_mode == pam_osc_xtal) begin
      next_owns[0] = 1'b1;
      next_oe_n[PIN_XOUT] = 1'b1;
      next_pin_out[PIN_XOUT] = 1'b0;
    end else if (clock6_on) begin
      next_oe_n[PIN_XOUT] = 1'b0;
      next_pin_out[PIN_XOUT] = div_cnt[DIV_W-1];
    end else if (!latch6_ok) begin
      next_oe_n[PIN_XOUT] = 1'b1;
      next_pin_out[PIN_XOUT] = 1'b0;
    end
    if (osc_mode != pam_osc_int) begin
      next_owns[1] = 1'b1;
      next_oe_n[PIN_XIN] = 1'b1;
      next_pin_out[PIN_XIN] = 1'b0;
    end
    next_din = pin_sync & ~(analog_select_a & ANSEL_MASK);
    next_din[PIN_XOUT] = pin_sync[PIN_XOUT] & latch6_ok;
    next_din[PIN_XIN] = pin_sync[PIN_XIN] & (osc_mode == pam_osc_int);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_out <= 8'h00;
      pin_oe_n <= 8'hff;
      osc_owns_pin <= 2'b00;
      digital_in <= 8'h00;
      instr_rate_clock <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_oe_n;
      osc_owns_pin <= next_owns;
      digital_in <= next_din;
      instr_rate_clock <= div_cnt[DIV_W-1];
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_a6_latch_out: assert property (
    (latch6_ok && !direction_ctrl_a[PIN_XOUT])
      |=> (!pin_oe_n[PIN_XOUT] && pin_out[PIN_XOUT] == $past(output_latch_a[PIN_XOUT])))
    else $error("pin 6 latch output wrong");
  a_a6_input_gate: assert property (
    !latch6_ok |=> !digital_in[PIN_XOUT])
    else $error("pin 6 input not gated");
  a_rc_clock_out: assert property (
    (osc_mode == pam_osc_rc)
      |=> (!pin_oe_n[PIN_XOUT] && pin_out[PIN_XOUT] == $past(div_cnt[DIV_W-1])))
    else $error("rc clock out missing");
  a_clock_period: assert property (
    $rose(instr_rate_clock) |=> instr_rate_clock ##1 !instr_rate_clock ##1 !instr_rate_clock)
    else $error("clock out not quarter rate");
  a_a7_ext_osc: assert property (
    (osc_mode != pam_osc_int) |=> (pin_oe_n[PIN_XIN] && !digital_in[PIN_XIN] && osc_owns_pin[1]))
    else $error("pin 7 not released");
  a_a4_priority: assert property (
    (cmp1_oe && capture_compare5_oe && !sr_q_en)
      |=> pin_out[PIN_SR_Q] == $past(comparator1_out))
    else $error("pin 4 priority wrong");
  a_a4_sr_top: assert property (
    sr_q_en |=> pin_out[PIN_SR_Q] == $past(sr_latch_q))
    else $error("pin 4 sr output lost");
  a_a4_third_src: assert property (
    (capture_compare5_oe && !cmp1_oe && !sr_q_en)
      |=> pin_out[PIN_SR_Q] == $past(capture_compare5_out))
    else $error("pin 4 third source lost");
  a_a5_sr_top: assert property (
    sr_qbar_en |=> pin_out[PIN_SR_QBAR] == $past(sr_latch_qbar))
    else $error("pin 5 sr output lost");
  a_a5_priority: assert property (
    (cmp2_oe && !sr_qbar_en)
      |=> pin_out[PIN_SR_QBAR] == $past(comparator2_out))
    else $error("pin 5 priority wrong");
  a_a5_latch_low: assert property (
    (!sr_qbar_en && !cmp2_oe)
      |=> pin_out[PIN_SR_QBAR] == $past(output_latch_a[PIN_SR_QBAR]))
    else $error("pin 5 latch output lost");
  a_a5_analog_drive: assert property (
    (analog_select_a[PIN_SR_QBAR] && !direction_ctrl_a[PIN_SR_QBAR] && cmp2_oe && !sr_qbar_en)
      |=> (!pin_oe_n[PIN_SR_QBAR]
        && pin_out[PIN_SR_QBAR] == $past(comparator2_out)))
    else $error("pin 5 analog drive wrong");
  a_a6_xtal_owns: assert property (
    (osc_mode == pam_osc_xtal) |=> (osc_owns_pin[0] && pin_oe_n[PIN_XOUT] && !digital_in[PIN_XOUT]))
    else $error("pin 6 not given to crystal");
  a_a6_clock_int: assert property (
    (osc_mode == pam_osc_int && clock_out_on)
      |=> (!pin_oe_n[PIN_XOUT] && pin_out[PIN_XOUT] == $past(div_cnt[DIV_W-1])))
    else $error("pin 6 clock out missing");
  a_a6_ext_off: assert property (
    (osc_mode == pam_osc_ext && !clock_out_on) |=> pin_oe_n[PIN_XOUT])
    else $error("pin 6 driven in external mode");
  a_a7_latch_out: assert property (
    (osc_mode == pam_osc_int && !direction_ctrl_a[PIN_XIN])
      |=> (!pin_oe_n[PIN_XIN] && !osc_owns_pin[1]
        && pin_out[PIN_XIN] == $past(output_latch_a[PIN_XIN])))
    else $error("pin 7 latch output wrong");
  a_dir_pin_off: assert property (
    (direction_ctrl_a[PIN_SR_Q] && sr_q_en) |=> pin_oe_n[PIN_SR_Q])
    else $error("pin 4 driver on while input");
  a_digital_din: assert property (
    !analog_select_a[1] |=> digital_in[1] == $past(pin_sync[1]))
    else $error("digital input blocked");
  a_port_read: assert property (
    (!hreadyout && regs.addr == OFF_PORT) |=> hrdata == {24'h000000, $past(digital_in)})
    else $error("pin level read wrong");
  a_lat_read: assert property (
    (!hreadyout && regs.addr == OFF_LAT) |=> hrdata == {24'h000000, $past(output_latch_a)})
    else $error("latch read wrong");
  a_ansel_unimpl: assert property (
    (analog_select_a & ~ANSEL_MASK) == 8'h00 && (slew_rate_ctrl & ~SLEW_MASK) == 8'h00)
    else $error("unimplemented bit set");
  a_dir_input: assert property (
    (direction_ctrl_a[3:0] == 4'hf) |=> (pin_oe_n[3:0] == 4'hf))
    else $error("driver on for input pin");
  a_analog_din: assert property (
    analog_select_a[0] |=> !digital_in[0])
    else $error("digital input not gated");
  a_latch_write: assert property (
    (regs.wr && (regs.addr == OFF_PORT || regs.addr == OFF_LAT))
      |=> output_latch_a == $past(regs.wdata[7:0]))
    else $error("latch write lost");

  c_rc_mode: cover property (osc_mode == pam_osc_rc ##1 $rose(instr_rate_clock));
  c_sr_drive: cover property (sr_q_en && cmp1_oe && !direction_ctrl_a[PIN_SR_Q]);
  c_ext_clock: cover property (osc_mode == pam_osc_ext ##1 osc_owns_pin == 2'b10);
  c_bus_read: cover property (!hreadyout ##1 hreadyout);
  c_xtal_mode: cover property (osc_mode == pam_osc_xtal ##1 osc_owns_pin == 2'b11);
endmodule

// [rtl/pam_reg_if.sv]
// register access carrier between bus slave and core
`timescale 1ns/100ps
interface pam_reg_if;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus(output wr, addr, wdata, input rdata);
  modport core(input wr, addr, wdata, output rdata);
endinterface

// [rtl/pam_sync.sv]
// three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pam_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1, s2, s3, next_out;
  // ==========================================
  // accept a change once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_out[i] = (s2[i] == s3[i]) ? s3[i] : sync_out[i];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sync_out <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= next_out;
    end
  end
endmodule

// [verification/pam_far_model.sv]
// far side of the pads: external levels and device drive resolved
`timescale 1ns/100ps
module pam_far_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // ======
  // pad level: device drive wins, else the external level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule

// [verification/port_a_pin_function_mux_test.sv]
// self-checking testbench for the port a pin function multiplexer
`timescale 1ns/100ps
module port_a_pin_function_mux_test;
  import pam_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [7:0] pin_in, pin_out, pin_oe_n, digital_in;
  logic [7:0] ext_level = 8'hff;
  logic [1:0] osc_owns_pin;
  logic [4:0] slew_limit;
  logic instr_rate_clock;
  logic [9:0] per = 0;
  logic [31:0] rd;
  int err_count = 0;
  int compares = 0;

  always #2 clock = ~clock;

  // ======
  // design and far side
  pam_port_a pam_port_a_inst (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .osc_owns_pin(osc_owns_pin),
    .digital_in(digital_in), .slew_limit(slew_limit),
    .instr_rate_clock(instr_rate_clock), .sr_latch_q(per[0]), .sr_q_en(per[1]),
    .sr_latch_qbar(per[2]), .sr_qbar_en(per[3]), .comparator1_out(per[4]),
    .cmp1_oe(per[5]), .comparator2_out(per[6]), .cmp2_oe(per[7]),
    .capture_compare5_out(per[8]), .capture_compare5_oe(per[9])
  );
  pam_far_model pam_far_model_inst (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level), .pin_in(pin_in)
  );

  // ======
  // common tasks
  task end_of_test;
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task rdy;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        end_of_test();
      end
      @(posedge clock);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task pv(input logic [9:0] v, input logic [1:0] exp);
    per <= v;
    repeat (3) @(posedge clock);
    chk("pin5_4", {30'h0, pin_out[5:4]}, {30'h0, exp});
  endtask

  // ======
  // scenarios
  task t_regs;
    rdchk("ansel", OFF_ANSEL, {24'h0, ANSEL_RST});
    rdchk("lat", OFF_LAT, 32'h0);
    rdchk("dir", OFF_DIR, 32'hff);
    rdchk("osc", OFF_OSC, 32'h0);
    bus(1'b1, OFF_ANSEL, 32'hff);
    rdchk("ansel_mask", OFF_ANSEL, 32'h2f);
    bus(1'b1, OFF_SLEW, 32'hff);
    rdchk("slew_mask", OFF_SLEW, 32'h1f);
    chk("slew_limit", {27'h0, slew_limit}, 32'h1f);
    bus(1'b1, OFF_PORT, 32'ha5);
    rdchk("lat_via_port", OFF_LAT, 32'ha5);
    rdchk("unmapped", OFF_NONE, 32'h0);
  endtask

  task t_prio;
    bus(1'b1, OFF_ANSEL, 32'h0);
    bus(1'b1, OFF_DIR, 32'h0);
    bus(1'b1, OFF_LAT, 32'h30);
    pv(10'h3fa, 2'b00);
    pv(10'h3a0, 2'b00);
    pv(10'h200, 2'b10);
    pv(10'h000, 2'b11);
    chk("oe_out", {26'h0, pin_oe_n[5:0]}, 32'h0);
    bus(1'b1, OFF_DIR, 32'h0f);
    repeat (3) @(posedge clock);
    chk("oe_in", {26'h0, pin_oe_n[5:0]}, 32'h0f);
    ext_level <= 8'ha5;
    repeat (8) @(posedge clock);
    chk("din_input", {28'h0, digital_in[3:0]}, 32'h5);
  endtask

  task t_analog;
    bus(1'b1, OFF_DIR, 32'h0);
    bus(1'b1, OFF_LAT, 32'h35);
    bus(1'b1, OFF_ANSEL, 32'h2f);
    repeat (8) @(posedge clock);
    chk("out_analog", {26'h0, pin_out[5:0]}, 32'h35);
    chk("din_analog", {24'h0, digital_in}, 32'h10);
    rdchk("port_rd", OFF_PORT, 32'h10);
    rdchk("lat_rd", OFF_LAT, 32'h35);
    bus(1'b1, OFF_ANSEL, 32'h0);
    repeat (8) @(posedge clock);
    chk("din_digital", {24'h0, digital_in}, 32'h35);
  endtask

  task t_osc;
    logic [2:0] md [7];
    logic [5:0] ex [7];
    md = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h3, 3'h7, 3'h6};
    ex = '{6'h0c, 6'h08, 6'h22, 6'h33, 6'h23, 6'h22, 6'h33};
    bus(1'b1, OFF_DIR, 32'h3f);
    bus(1'b1, OFF_LAT, 32'hc0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, OFF_OSC, {29'h0, md[i]});
      repeat (8) @(posedge clock);
      chk("osc_pins", {26'h0, osc_owns_pin, digital_in[7:6], pin_oe_n[7:6]}, ex[i]);
    end
  endtask

  task t_clk;
    int n;
    logic [3:0] s, p;
    s = 4'h0;
    p = 4'h0;
    n = 0;
    bus(1'b1, OFF_OSC, 32'h1);
    while (instr_rate_clock !== 1'b0 && n < 8) begin
      @(posedge clock);
      n++;
    end
    while (instr_rate_clock !== 1'b1 && n < 16) begin
      @(posedge clock);
      n++;
    end
    if (instr_rate_clock !== 1'b1) begin
      err_count++;
      end_of_test();
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      s = {s[2:0], instr_rate_clock};
      p = {p[2:0], pin_out[6]};
    end
    chk("quarter_clock", {28'h0, s}, 32'h9);
    chk("pin6_clock", {28'h0, p}, 32'h9);
    chk("clock_drive", {31'h0, pin_oe_n[6]}, 32'h0);
    bus(1'b1, OFF_OSC, 32'h0);
  endtask

  // ======
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_prio();
    t_analog();
    t_osc();
    t_clk();
    end_of_test();
  end
endmodule
